// >>> mbrd_bitpack.sv
`include "mbrd_params.svh"

module mbrd_bitpack (
   // clock and reset, used only by checks
   input wire logic clk,
   input wire logic rst_n,
   // packing request and packed byte
   mbrd_pack_if.packer pk
);
   import mbrd_pkg::*;

   logic [16:0] base;
   logic [16:0] rel;
   logic [16:0] pos;

   ////////////////////////////////////////////////////////////////////////
   // one byte of bit statuses, first item in the lsb
   always_comb begin
      base = {6'h00, pk.byte_idx, 3'h0};
      pk.data = 8'h00;
      rel = 17'h00000;
      pos = 17'h00000;
      for (int b = 0; b < 8; b++) begin
         rel = base + 17'(b);
         pos = {1'b0, pk.start} + rel;
         // beyond the quantity or the space stays zero
         if (rel < {1'b0, pk.qty} && pos <= `MB_BIT_ADDR_MAX) begin
            pk.data[b] = pk.space[pos[4:0]];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   chk_pad_zero: assert property (@(posedge clk) disable iff (!rst_n)
      ({6'h00, pk.byte_idx, 3'h7} >= {1'b0, pk.qty}) |-> !pk.data[7])
      else $error("pad bit above quantity not zero");

   chk_lsb_first: assert property (@(posedge clk) disable iff (!rst_n)
      ({6'h00, pk.byte_idx, 3'h0} < {1'b0, pk.qty} &&
       {1'b0, pk.start} + {6'h00, pk.byte_idx, 3'h0} <= `MB_BIT_ADDR_MAX)
      |-> pk.data[0] ==
          pk.space[5'(pk.start + {5'h00, pk.byte_idx, 3'h0})])
      else $error("first item not in bit zero");
endmodule

// >>> mbrd_master_model.sv
module mbrd_master_model (
   // clock
   input wire logic clk,
   // request stream toward the server
   output logic req_valid,
   output logic [7:0] req_data,
   output logic req_last,
   input wire logic req_ready,
   // response stream from the server
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_data,
   input wire logic rsp_last,
   output logic rsp_ready
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle until the bench starts a frame
   initial begin
      req_valid = 1'b0;
      req_data = 8'h5A;
      req_last = 1'b0;
      rsp_ready = 1'b1;
   end

   ////////////////////////////////////////
   // one frame out, answer back; slow stalls every other cycle
   task automatic xfer(input logic [7:0] req[$], input bit slow,
                       input bit want, output logic [7:0] rsp[$]);
      int guard;
      bit done;
      rsp = {};
      guard = 0;
      done = 0;
      foreach (req[i]) begin
         req_valid <= 1'b1;
         req_data <= req[i];
         req_last <= (i == req.size() - 1);
         @(negedge clk);
         while (!req_ready) @(negedge clk);
         @(posedge clk);
      end
      // released data line must not look like a held byte
      req_valid <= 1'b0;
      req_last <= 1'b0;
      req_data <= ~req_data;
      while (want && !done && guard < 1200) begin
         if (slow) rsp_ready <= guard[0];
         @(negedge clk);
         if (rsp_valid && rsp_ready) begin
            rsp.push_back(rsp_data);
            done = rsp_last;
         end
         @(posedge clk);
         guard++;
      end
      rsp_ready <= 1'b1;
      @(posedge clk);
   endtask
endmodule

// >>> mbrd_pack_if.sv
interface mbrd_pack_if;
   logic [24:0] space;
   logic [15:0] start;
   logic [15:0] qty;
   logic [7:0] byte_idx;
   logic [7:0] data;

   modport server (
      output space,
      output start,
      output qty,
      output byte_idx,
      input data
   );

   modport packer (
      input space,
      input start,
      input qty,
      input byte_idx,
      output data
   );
endinterface

// >>> mbrd_params.svh
`ifndef MBRD_PARAMS_SVH
`define MBRD_PARAMS_SVH

// function codes handled here or passed on
`define MB_FC_RD_COILS 8'h01
`define MB_FC_RD_DISC 8'h02
`define MB_FC_RD_HOLD 8'h03
`define MB_FC_RD_INPUT 8'h04
`define MB_FC_WR_COIL 8'h05
`define MB_FC_WR_REG 8'h06
`define MB_FC_DIAG 8'h08
`define MB_FC_WR_COILS 8'h0F
`define MB_FC_WR_REGS 8'h10
`define MB_FC_MASK_WR 8'h16
`define MB_FC_EXC_FLAG 8'h80

// exception codes
`define MB_EXC_ILL_FN 8'h01
`define MB_EXC_ILL_ADDR 8'h02
`define MB_EXC_ILL_VALUE 8'h03

// quantity limits
`define MB_QTY_MIN 16'h0001
`define MB_BIT_QTY_MAX 16'h07D0
`define MB_REG_QTY_MAX 16'h007D

// highest coil or input address accepted
`define MB_BIT_ADDR_MAX 17'h00018

// request header length: code, address, quantity
`define MB_REQ_BYTES 3'h5

// digital port registers in the register space
`define MB_DPORT_BASE 16'h0000
`define MB_DPORT_COUNT 16'h0003

`endif

// >>> mbrd_pkg.sv
package mbrd_pkg;

   // sequencing of one request
   typedef enum logic [2:0] {
      ST_RX,
      ST_CHECK,
      ST_SCAN,
      ST_LOAD,
      ST_SEND
   } mbrd_state_t;

endpackage

// >>> mbrd_server.sv
`include "mbrd_params.svh"

module mbrd_server (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // request bytes from the framing layer
   input wire logic req_valid,
   input wire logic [7:0] req_data,
   input wire logic req_last,
   output logic req_ready,
   // response bytes to the framing layer
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_last,
   input wire logic rsp_ready,
   // supported functions served elsewhere
   output logic fwd_valid,
   output logic [7:0] fwd_code,
   // digital port pins and output latches
   input wire logic [23:0] port_line,
   input wire logic [23:0] port_latch,
   // register file read port, answers in the same cycle
   output logic [15:0] reg_rd_addr,
   output logic reg_rd_holding,
   input wire logic [15:0] reg_rd_data,
   input wire logic reg_rd_ok
);
   import mbrd_pkg::*;

   mbrd_pack_if pk ();

   mbrd_state_t state, next_state;
   logic [7:0] fc, next_fc;
   logic [15:0] start, next_start;
   logic [15:0] qty, next_qty;
   logic [2:0] rx_cnt, next_rx_cnt;
   logic [7:0] idx, next_idx;
   logic [7:0] len, next_len;
   logic exc, next_exc;
   logic [7:0] exc_code, next_exc_code;
   logic [7:0] out_byte, next_out_byte;
   logic next_fwd_valid;
   logic [7:0] next_fwd_code;
   logic [23:0] line_meta;
   logic [23:0] line_s;

   logic is_bit, is_reg, qty_ok, rx_full;
   logic [16:0] last17;
   logic [7:0] count;
   logic [7:0] ld;
   logic [7:0] ld_off;
   logic in_dport;
   logic [1:0] dport_idx;
   logic [15:0] dport_off;
   logic [15:0] reg_val;
   logic [7:0] rb;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic fn_supported(input logic [7:0] f);
      return f inside {`MB_FC_RD_COILS, `MB_FC_RD_DISC, `MB_FC_RD_HOLD,
                       `MB_FC_RD_INPUT, `MB_FC_WR_COIL, `MB_FC_WR_REG,
                       `MB_FC_DIAG, `MB_FC_WR_COILS, `MB_FC_WR_REGS,
                       `MB_FC_MASK_WR};
   endfunction

   // whole bytes needed for q bits; q is at most 2000 whenever the result is sent
   function automatic logic [7:0] bit_bytes(input logic [15:0] q);
      return 8'((q + 16'h0007) >> 3);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pins cross into the clock domain before anything reads them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line_meta <= 24'h000000;
         line_s <= 24'h000000;
      end else begin
         line_meta <= port_line;
         line_s <= line_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // request decode
   assign is_bit = (fc == `MB_FC_RD_COILS) || (fc == `MB_FC_RD_DISC);
   assign is_reg = (fc == `MB_FC_RD_HOLD) || (fc == `MB_FC_RD_INPUT);
   assign rx_full = (rx_cnt == `MB_REQ_BYTES);
   // addresses are used as sent, no offset of one
   assign last17 = {1'b0, start} + {1'b0, qty} - 17'h00001;
   // bit reads take up to 2000, register reads up to 125
   assign qty_ok = qty >= `MB_QTY_MIN &&
                   qty <= (is_bit ? `MB_BIT_QTY_MAX : `MB_REG_QTY_MAX);
   // byte count: qty is at most 125 here, so 2N fits a byte
   assign count = is_bit ? bit_bytes(qty) : {qty[6:0], 1'b0};

   ////////////////////////////////////////////////////////////////////////
   // index of the byte being loaded, and register addressing
   assign ld = (state == ST_SEND) ? idx + 8'h01 : 8'h00;
   assign ld_off = ld - 8'h02;
   assign reg_rd_addr = (state == ST_SCAN) ? start + {8'h00, idx}
                                           : start + {9'h000, ld_off[7:1]};
   // file answers for writable, non converter registers only
   assign reg_rd_holding = (fc == `MB_FC_RD_HOLD);
   assign dport_off = reg_rd_addr - `MB_DPORT_BASE;
   assign in_dport = reg_rd_addr >= `MB_DPORT_BASE &&
                     dport_off < `MB_DPORT_COUNT;
   assign dport_idx = dport_off[1:0];
   // ports read as latches for holding, as lines for input
   always_comb begin
      if (!in_dport) begin
         reg_val = reg_rd_data;
      end else if (reg_rd_holding) begin
         reg_val = {8'h00, port_latch[dport_idx*8 +: 8]};
      end else begin
         reg_val = {8'h00, line_s[dport_idx*8 +: 8]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bit packing: coils are output latches, inputs the synced lines
   assign pk.space = (fc == `MB_FC_RD_COILS) ? {1'b0, port_latch}
                                              : {1'b0, line_s};
   assign pk.start = start;
   assign pk.qty = qty;
   assign pk.byte_idx = ld_off;

   mbrd_bitpack u_pack (
      .clk(clk),
      .rst_n(rst_n),
      .pk(pk.packer)
   );

   ////////////////////////////////////////////////////////////////////////
   // response byte for index ld
   always_comb begin
      if (ld == 8'h00) begin
         rb = exc ? (fc | `MB_FC_EXC_FLAG) : fc;
      end else if (ld == 8'h01) begin
         rb = exc ? exc_code : count;
      end else if (is_bit) begin
         rb = pk.data;
      end else begin
         rb = ld_off[0] ? reg_val[7:0] : reg_val[15:8];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // request and response sequencing
   always_comb begin
      next_state = state;
      next_fc = fc;
      next_start = start;
      next_qty = qty;
      next_rx_cnt = rx_cnt;
      next_idx = idx;
      next_len = len;
      next_exc = exc;
      next_exc_code = exc_code;
      next_out_byte = out_byte;
      next_fwd_valid = 1'b0;
      next_fwd_code = fwd_code;
      unique case (state)
         ST_RX: begin
            if (req_valid) begin
               // bytes past the header are ignored
               unique case (rx_cnt)
                  3'h0: next_fc = req_data;
                  3'h1: next_start[15:8] = req_data;
                  3'h2: next_start[7:0] = req_data;
                  3'h3: next_qty[15:8] = req_data;
                  3'h4: next_qty[7:0] = req_data;
                  default: ;
               endcase
               if (!rx_full) begin
                  next_rx_cnt = rx_cnt + 3'h1;
               end
               if (req_last) begin
                  next_state = ST_CHECK;
               end
            end
         end
         ST_CHECK: begin
            next_exc = 1'b0;
            next_idx = 8'h00;
            next_rx_cnt = 3'h0;
            next_state = ST_LOAD;
            if (!fn_supported(fc)) begin
               next_exc = 1'b1;
               next_exc_code = `MB_EXC_ILL_FN;
            end else if (!(is_bit || is_reg)) begin
               // writes and diagnostics go to their own handler
               next_fwd_valid = 1'b1;
               next_fwd_code = fc;
               next_state = ST_RX;
            end else if (!rx_full || !qty_ok) begin
               next_exc = 1'b1;
               next_exc_code = `MB_EXC_ILL_VALUE;
            end else if (is_bit) begin
               if (last17 > `MB_BIT_ADDR_MAX) begin
                  next_exc = 1'b1;
                  next_exc_code = `MB_EXC_ILL_ADDR;
               end
            end else if (last17[16]) begin
               next_exc = 1'b1;
               next_exc_code = `MB_EXC_ILL_ADDR;
            end else begin
               next_state = ST_SCAN;
            end
         end
         ST_SCAN: begin
            // every address is proven before the first byte leaves
            if (!(in_dport || reg_rd_ok)) begin
               next_exc = 1'b1;
               next_exc_code = `MB_EXC_ILL_ADDR;
               next_state = ST_LOAD;
            end else if ({8'h00, idx} == qty - 16'h0001) begin
               next_state = ST_LOAD;
            end else begin
               next_idx = idx + 8'h01;
            end
         end
         ST_LOAD: begin
            next_idx = 8'h00;
            next_len = exc ? 8'h02 : count + 8'h02;
            next_out_byte = rb;
            next_state = ST_SEND;
         end
         ST_SEND: begin
            if (rsp_ready) begin
               if (idx == len - 8'h01) begin
                  next_state = ST_RX;
               end else begin
                  next_idx = idx + 8'h01;
                  next_out_byte = rb;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_RX;
         fc <= 8'h00;
         start <= 16'h0000;
         qty <= 16'h0000;
         rx_cnt <= 3'h0;
         idx <= 8'h00;
         len <= 8'h00;
         exc <= 1'b0;
         exc_code <= 8'h00;
         out_byte <= 8'h00;
         fwd_valid <= 1'b0;
         fwd_code <= 8'h00;
      end else begin
         state <= next_state;
         fc <= next_fc;
         start <= next_start;
         qty <= next_qty;
         rx_cnt <= next_rx_cnt;
         idx <= next_idx;
         len <= next_len;
         exc <= next_exc;
         exc_code <= next_exc_code;
         out_byte <= next_out_byte;
         fwd_valid <= next_fwd_valid;
         fwd_code <= next_fwd_code;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // byte streams; a new request waits until the answer is out
   assign req_ready = (state == ST_RX);
   assign rsp_valid = (state == ST_SEND);
   assign rsp_data = out_byte;
   assign rsp_last = rsp_valid && (idx == len - 8'h01);

   ////////////////////////////////////////////////////////////////////////
   chk_exc_fn_byte: assert property (@(posedge clk) disable iff (!rst_n)
      (rsp_valid && idx == 8'h00 && exc) |->
         rsp_data == (fc | `MB_FC_EXC_FLAG) && len == 8'h02)
      else $error("exception function byte wrong");
   chk_ill_fn_code: assert property (@(posedge clk) disable iff (!rst_n)
      (rsp_valid && idx == 8'h01 && !fn_supported(fc)) |->
         exc && rsp_data == `MB_EXC_ILL_FN)
      else $error("unsupported code not answered with 01");
   chk_bit_count: assert property (@(posedge clk) disable iff (!rst_n)
      (rsp_valid && idx == 8'h01 && !exc && is_bit) |->
         rsp_data == 8'((qty + 16'h0007) >> 3))
      else $error("bit byte count wrong");
   chk_reg_count: assert property (@(posedge clk) disable iff (!rst_n)
      (rsp_valid && idx == 8'h01 && !exc && is_reg) |->
         rsp_data == 8'(qty * 16'h0002) && len == 8'(qty * 16'h0002 + 16'h2))
      else $error("register byte count wrong");
   chk_qty_bad: assert property (@(posedge clk) disable iff (!rst_n)
      (state == ST_CHECK && (is_bit || is_reg) && rx_full && !qty_ok) |=>
         exc && exc_code == `MB_EXC_ILL_VALUE ##1 state == ST_SEND)
      else $error("bad quantity not answered with 03");
   chk_coil_range: assert property (@(posedge clk) disable iff (!rst_n)
      (state == ST_CHECK && is_bit && rx_full && qty_ok &&
       last17 > `MB_BIT_ADDR_MAX) |=>
         exc && exc_code == `MB_EXC_ILL_ADDR && state == ST_LOAD)
      else $error("coil address above range not rejected");
   chk_fwd_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      (state == ST_CHECK && fn_supported(fc) && !is_bit && !is_reg) |=>
         fwd_valid && fwd_code == $past(fc) && state == ST_RX ##1 !fwd_valid)
      else $error("other supported code not handed on");
   chk_line_sync: assert property (@(posedge clk) disable iff (!rst_n)
      $past(rst_n, 2) |-> line_s == $past(port_line, 2))
      else $error("port lines not two stage synced");
endmodule

// >>> modbus_read_function_server_tb.sv
`include "mbrd_params.svh"

module modbus_read_function_server_tb;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {
      logic [7:0] code;
      logic [15:0] start;
      logic [15:0] qty;
      logic [7:0] exc;
      bit slow;
   } mbrd_row_t;

   logic clk, rst_n, req_valid, req_last, req_ready;
   logic rsp_valid, rsp_last, rsp_ready, fwd_valid;
   logic reg_rd_holding, reg_rd_ok;
   logic [7:0] req_data, rsp_data, fwd_code;
   logic [23:0] port_line, port_latch;
   logic [15:0] reg_rd_addr, reg_rd_data;
   logic [7:0] got[$];
   logic [7:0] bad[8] = '{8'h00, 8'h07, 8'h09, 8'h0E, 8'h11, 8'h17,
                          8'h80, 8'hFF};
   logic [7:0] fwd[6] = '{8'h05, 8'h06, 8'h08, 8'h0F, 8'h10, 8'h16};
   int num_errors = 0;
   int total_checks = 0;
   int fwd_seen = 0;
   // code, start, quantity, exception expected, slow consumer
   mbrd_row_t rows[17] = '{
      '{8'h01, 16'h0000, 16'h0003, 8'h00, 1'b0},
      '{8'h01, 16'h0005, 16'h0014, 8'h00, 1'b1},
      '{8'h01, 16'h0000, 16'h0019, 8'h00, 1'b0},
      '{8'h01, 16'h0000, 16'h001A, 8'h02, 1'b0},
      '{8'h01, 16'h0000, 16'h0000, 8'h03, 1'b0},
      '{8'h01, 16'h0000, 16'h07D1, 8'h03, 1'b0},
      '{8'h01, 16'h0000, 16'h07D0, 8'h02, 1'b0},
      '{8'h02, 16'h0003, 16'h0010, 8'h00, 1'b1},
      '{8'h02, 16'h0019, 16'h0001, 8'h02, 1'b0},
      '{8'h03, 16'h0000, 16'h0005, 8'h00, 1'b0},
      '{8'h03, 16'h001F, 16'h0002, 8'h02, 1'b0},
      '{8'h03, 16'h0000, 16'h007E, 8'h03, 1'b0},
      '{8'h03, 16'h0004, 16'h0002, 8'h00, 1'b1},
      '{8'h04, 16'h0000, 16'h0005, 8'h00, 1'b0},
      '{8'h04, 16'h0000, 16'h007D, 8'h00, 1'b0},
      '{8'h04, 16'h0000, 16'h007E, 8'h03, 1'b0},
      '{8'h04, 16'hFFFF, 16'h0002, 8'h02, 1'b0}
   };

   mbrd_server u_dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
      .req_data(req_data), .req_last(req_last), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last),
      .rsp_ready(rsp_ready), .fwd_valid(fwd_valid), .fwd_code(fwd_code),
      .port_line(port_line), .port_latch(port_latch),
      .reg_rd_addr(reg_rd_addr), .reg_rd_holding(reg_rd_holding),
      .reg_rd_data(reg_rd_data), .reg_rd_ok(reg_rd_ok));

   mbrd_master_model u_master (.clk(clk), .req_valid(req_valid),
      .req_data(req_data), .req_last(req_last), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last),
      .rsp_ready(rsp_ready));

   function automatic logic [15:0] reg_val(input logic [15:0] a);
      return {a[7:0] ^ 8'hC3, a[7:0]};
   endfunction

   ////////////////////////////////////////
   // register file stand-in; holding space stops short of converters
   always_comb begin
      reg_rd_ok = (reg_rd_addr >= 16'h0003) &&
         (reg_rd_addr < (reg_rd_holding ? 16'h0020 : 16'h0100));
      reg_rd_data = reg_val(reg_rd_addr);
   end

   // free running clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // count forward pulses, one per forwarded frame
   always @(posedge clk) begin
      if (fwd_valid === 1'b1) fwd_seen++;
   end

   task automatic check(input logic [31:0] seen, exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s seen %h wanted %h", $time, what,
                  seen, exp);
      end
   endtask

   task automatic results;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // expected answer worked out bit by bit from the port images for bit reads, from the ports and reg_val for registers
   function automatic void expect_rsp(input mbrd_row_t r,
                                      output logic [7:0] q[$]);
      int n, idx;
      logic [15:0] v;
      logic [7:0] b;
      q = {r.code};
      if (r.exc !== 8'h00) begin
         q = {r.code | `MB_FC_EXC_FLAG, r.exc};
         return;
      end
      if (r.code <= 8'h02) begin
         n = (r.qty + 7) / 8;
         q.push_back(n[7:0]);
         for (int i = 0; i < n; i++) begin
            b = 8'h00;
            for (int k = 0; k < 8; k++) begin
               idx = r.start + i * 8 + k;
               if (i * 8 + k < r.qty && idx < 24)
                  b[k] = (r.code == 8'h01) ? port_latch[idx] : port_line[idx];
            end
            q.push_back(b);
         end
      end else begin
         q.push_back({r.qty[6:0], 1'b0});
         for (int j = 0; j < r.qty; j++) begin
            idx = r.start + j;
            v = reg_val(idx[15:0]);
            if (idx < 3)
               v = {8'h00, (r.code == 8'h03) ? port_latch[idx*8 +: 8]
                                             : port_line[idx*8 +: 8]};
            q.push_back(v[15:8]);
            q.push_back(v[7:0]);
         end
      end
   endfunction

   task automatic run_row(input mbrd_row_t r);
      logic [7:0] exp[$];
      u_master.xfer({r.code, r.start[15:8], r.start[7:0], r.qty[15:8],
                     r.qty[7:0]}, r.slow, 1'b1, got);
      expect_rsp(r, exp);
      check(got.size(), exp.size(), "response length");
      foreach (exp[i]) begin
         check(got[i], exp[i], "response byte");
      end
   endtask

   // hang guard, far beyond the longest expected run
   initial begin
      repeat (40000) @(posedge clk);
      num_errors++;
      $display("mismatch at %0t: run did not finish", $time);
      results;
   end

   ////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      port_line = 24'h5AC3E1;
      port_latch = 24'h96F00F;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (rows[i]) run_row(rows[i]);
      check(fwd_seen, 0, "read forwarded");
      // fresh line levels reach reads only through the synchroniser
      port_line <= 24'h3C965A;
      repeat (2) @(posedge clk);
      run_row(rows[7]);
      run_row(rows[13]);
      foreach (bad[i]) run_row('{bad[i], 16'h0000, 16'h0001, 8'h01, 1'b0});
      // supported non-read codes leave the block as one pulse
      foreach (fwd[i]) begin
         fwd_seen = 0;
         u_master.xfer({fwd[i], 8'h00, 8'h01, 8'hFF, 8'h00}, 1'b0, 1'b0, got);
         repeat (4) @(posedge clk);
         check(fwd_seen, 1, "forward pulse count");
         check(fwd_code, fwd[i], "forward code");
      end
      // truncated read frame has no quantity
      u_master.xfer({8'h03, 8'h00, 8'h00}, 1'b0, 1'b1, got);
      check({got[0], got[1]}, 16'h8303, "short frame");
      // reset while a holding scan is under way
      u_master.xfer({8'h03, 8'h00, 8'h00, 8'h00, 8'h1F}, 1'b0, 1'b0, got);
      repeat (3) @(posedge clk);
      rst_n <= 1'b0;
      @(negedge clk);
      check({req_ready, rsp_valid, rsp_last, reg_rd_holding}, 4'h8,
            "reset flags");
      check({rsp_data, fwd_code, 7'h00, fwd_valid}, 24'h0, "reset data");
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      run_row(rows[0]);
      results;
   end
endmodule
